// ==== verilog/fwp_write_protect.sv ====
// Purpose: write-enable latch, busy, range and region protection, status write guard
// Assumes: decoded instructions arrive on spi_clk; reset_n is the supply-level reset
// Notes:   array operations are only timed here, the array itself is elsewhere
// Contract
// - supply reset disables everything, no instruction recognized
// - after power-up, write-type and write-enable instructions rejected for inhibit time
// - power-up leaves write-enable latch at 0
// - program, erase and status write need write-enable latch set first
// - latch cleared when a program, erase or status write finishes
// - in power-down only release-from-power-down is obeyed
// - one lock bit per middle block, per sector in top and bottom blocks
// - set lock bit blocks erase and program of its region
// - all lock bits set to 1 at power-on
// - unlock instruction 39h clears the addressed region's lock bit
// - scheme select 0 uses range fields, 1 uses lock bits
// - status write gated by protect mode, latch and protect pin
// - busy bit high during program, erase, status or security operation
// - while busy only status reads and suspend are obeyed
// - latch set by write enable, cleared by write disable and write operations
// - range field sits in status bits 4..2, default 0 protects nothing
// - top/bottom select 0 protects from top, 1 from bottom
// - sector select 1 counts 4KB sectors, 0 counts 64KB blocks
// - complement bit inverts the protected region, default 0
// - protect mode 00 needs only the latch, pin ignored
// - protect mode 01 locks status while pin low
// - mode 10 locks until power cycle, mode 11 forever; here mode 11 also clears at the supply reset, like mode 10
// - quad enable disables the protect pin function
// - lock bits also return to 1 after reset
`include "fwp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module fwp_write_protect #(
   parameter int BLOCKS = 64,
   parameter int PUW_CYCLES = `FWP_PUW_TIME_US * `FWP_CORE_MHZ,
   parameter int OP_CYCLES = `FWP_OP_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic spi_clk,
   input wire logic cmd_strobe,
   input wire logic [7:0] cmd_code,
   input wire logic [$clog2(BLOCKS)+`FWP_BLK_LSB-1:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   input wire logic wp_n_pin,
   output logic [7:0] status_one,
   output logic [7:0] status_two,
   output logic protect_scheme_select,
   output logic op_start,
   output logic [2:0] op_kind,
   output logic [$clog2(BLOCKS)+`FWP_BLK_LSB-1:0] op_addr,
   output logic cmd_ignored
);
   localparam int ADDR_W = $clog2(BLOCKS) + `FWP_BLK_LSB;
   localparam int BLK_W = ADDR_W - `FWP_BLK_LSB;
   localparam int LOCKS = BLOCKS - 2 + `FWP_EDGE_SECTORS;
   localparam int LOCK_W = $clog2(LOCKS);
   localparam int PUW_W = $clog2(PUW_CYCLES + 1);
   localparam int OP_W = $clog2(OP_CYCLES + 1);

   // link side: hold the decoded instruction and flag it with a toggle
   logic lk_tgl_r;
   logic [7:0] lk_code_r;
   logic [ADDR_W-1:0] lk_addr_r;
   logic [15:0] lk_data_r;

   // core side state
   logic tg_s1_r, tg_s2_r, tg_s3_r;
   logic wp_s1_r, wp_s2_r;
   fwp_pkg::fwp_state_t state_r;
   logic [PUW_W-1:0] puw_cnt_r;
   logic [OP_W-1:0] op_cnt_r;
   logic wel_r, reset_armed_r;
   logic [2:0] bp_r;
   logic tb_r, sec_r, protect_mode_low_r, protect_mode_high_r, qe_r, cmp_r, wps_r;
   logic [LOCKS-1:0] lock_r;
   logic op_start_r, cmd_ignored_r;
   fwp_pkg::fwp_op_t op_kind_r;
   logic [ADDR_W-1:0] op_addr_r;

   // decode results
   logic take, st_inhibit, st_ready, st_busy, st_pdown;
   fwp_pkg::fwp_op_t op_nxt;
   logic [ADDR_W-1:0] op_mask;
   logic prot_hit, sr_wr_ok, go_op, op_done;
   logic wren_go, wrdi_go, unl_go, pd_go, rdp_go, arm_go, rst_go, read_ok, susp_ok;
   logic [LOCK_W-1:0] unl_idx;

   // range-protect lookup for one address
   function automatic logic fwp_in_range(input logic [ADDR_W-1:0] a, input logic [2:0] bp,
                                         input logic tb, input logic sec, input logic cmp);
      logic [ADDR_W:0] len;
      logic [2:0] sh;
      logic hit;
      len = '0;
      sh = 3'h0;
      hit = 1'b0;
      if (bp == 3'h7) begin
         hit = 1'b1;
      end else if (bp != 3'h0) begin
         // sector granules stop growing at eight sectors
         sh = (sec && bp > 3'h4) ? 3'h3 : bp - 3'h1;
         len = (sec ? (ADDR_W+1)'(`FWP_SECTOR_BYTES) : (ADDR_W+1)'(`FWP_BLOCK_BYTES)) << sh;
         hit = tb ? ({1'b0, a} < len) : ({1'b0, a} >= ({1'b1, {ADDR_W{1'b0}}} - len));
      end
      return hit ^ cmp;
   endfunction

   // lock bit index: bottom sectors 0..15, top sectors 16..31, middle blocks above
   function automatic logic [LOCK_W-1:0] fwp_lock_index(input logic [ADDR_W-1:0] a);
      logic [BLK_W-1:0] blk;
      logic [LOCK_W-1:0] idx;
      blk = a[ADDR_W-1:`FWP_BLK_LSB];
      if (blk == '0) begin
         idx = LOCK_W'(a[`FWP_BLK_LSB-1:`FWP_SECT_LSB]);
      end else if (blk == BLK_W'(BLOCKS - 1)) begin
         idx = LOCK_W'({1'b1, a[`FWP_BLK_LSB-1:`FWP_SECT_LSB]});
      end else begin
         idx = LOCK_W'(blk) + LOCK_W'(`FWP_EDGE_SECTORS - 1);
      end
      return idx;
   endfunction

   // link capture; held words are read by the core only after the toggle is synced
   always_ff @(posedge spi_clk or negedge reset_n) begin
      if (!reset_n) begin
         lk_tgl_r <= 1'b0;
         lk_code_r <= 8'h00;
         lk_addr_r <= '0;
         lk_data_r <= 16'h0000;
      end else if (cmd_strobe) begin
         lk_tgl_r <= ~lk_tgl_r;
         lk_code_r <= cmd_code;
         lk_addr_r <= cmd_addr;
         lk_data_r <= cmd_data;
      end
   end

   // toggle and protect pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
         wp_s1_r <= 1'b1;
         wp_s2_r <= 1'b1;
      end else begin
         tg_s1_r <= lk_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
         wp_s1_r <= wp_n_pin;
         wp_s2_r <= wp_s1_r;
      end
   end

   assign take = tg_s2_r ^ tg_s3_r;
   assign st_inhibit = (state_r == fwp_pkg::FWP_ST_INHIBIT);
   assign st_ready = (state_r == fwp_pkg::FWP_ST_READY);
   assign st_busy = (state_r == fwp_pkg::FWP_ST_BUSY);
   assign st_pdown = (state_r == fwp_pkg::FWP_ST_PDOWN);
   assign op_done = st_busy && (op_cnt_r == OP_W'(OP_CYCLES - 1));

   // which timed operation an instruction asks for
   always_comb begin
      op_nxt = fwp_pkg::FWP_OP_NONE;
      op_mask = '0;
      case (lk_code_r)
         `FWP_CMD_PAGE_PROG, `FWP_CMD_QUAD_PROG: begin
            op_nxt = fwp_pkg::FWP_OP_PROG;
            op_mask = ADDR_W'(`FWP_PAGE_MASK);
         end
         `FWP_CMD_SECT_ERASE: begin
            op_nxt = fwp_pkg::FWP_OP_SECT_ERASE;
            op_mask = ADDR_W'(`FWP_SECT_MASK);
         end
         `FWP_CMD_BLOCK_ERASE: begin
            op_nxt = fwp_pkg::FWP_OP_BLOCK_ERASE;
            op_mask = ADDR_W'(`FWP_BLOCK_MASK);
         end
         `FWP_CMD_CHIP_ERASE, `FWP_CMD_CHIP_ERASE2: begin
            op_nxt = fwp_pkg::FWP_OP_CHIP_ERASE;
         end
         `FWP_CMD_STATUS_WR, `FWP_CMD_STATUS3_WR: begin
            op_nxt = fwp_pkg::FWP_OP_STATUS_WR;
         end
         `FWP_CMD_SECREG_ERASE, `FWP_CMD_SECREG_PROG: begin
            op_nxt = fwp_pkg::FWP_OP_SECREG;
         end
         default: begin
            op_nxt = fwp_pkg::FWP_OP_NONE;
         end
      endcase
   end

   // array protection check for the held target
   always_comb begin
      prot_hit = 1'b0;
      if (!wps_r) begin
         // range fields only; a range straddling the target's end is caught too
         if (op_nxt == fwp_pkg::FWP_OP_CHIP_ERASE) begin
            prot_hit = cmp_r ? (bp_r != 3'h7) : (bp_r != 3'h0);
         end else begin
            prot_hit = fwp_in_range(lk_addr_r, bp_r, tb_r, sec_r, cmp_r)
                       || fwp_in_range(lk_addr_r | op_mask, bp_r, tb_r, sec_r, cmp_r);
         end
      end else begin
         // lock bits only; an edge block erase needs all its sectors open
         case (op_nxt)
            fwp_pkg::FWP_OP_CHIP_ERASE: prot_hit = |lock_r;
            fwp_pkg::FWP_OP_BLOCK_ERASE: begin
               if (lk_addr_r[ADDR_W-1:`FWP_BLK_LSB] == '0) begin
                  prot_hit = |lock_r[15:0];
               end else if (lk_addr_r[ADDR_W-1:`FWP_BLK_LSB] == BLK_W'(BLOCKS - 1)) begin
                  prot_hit = |lock_r[31:16];
               end else begin
                  prot_hit = lock_r[fwp_lock_index(lk_addr_r)];
               end
            end
            fwp_pkg::FWP_OP_PROG, fwp_pkg::FWP_OP_SECT_ERASE: begin
               prot_hit = lock_r[fwp_lock_index(lk_addr_r)];
            end
            default: prot_hit = 1'b0;
         endcase
      end
      if (op_nxt == fwp_pkg::FWP_OP_STATUS_WR || op_nxt == fwp_pkg::FWP_OP_SECREG) begin
         prot_hit = 1'b0;
      end
   end

   // status write guard: quad mode turns the pin into data, so it cannot lock
   assign sr_wr_ok = wel_r && !protect_mode_high_r && (!protect_mode_low_r || qe_r || wp_s2_r);

   // accepted instructions
   assign go_op = take && st_ready && (op_nxt != fwp_pkg::FWP_OP_NONE) && wel_r
                  && ((op_nxt == fwp_pkg::FWP_OP_STATUS_WR) ? sr_wr_ok : !prot_hit);
   assign wren_go = take && st_ready && (lk_code_r == `FWP_CMD_WR_ENABLE);
   assign wrdi_go = take && (st_ready || st_inhibit) && (lk_code_r == `FWP_CMD_WR_DISABLE);
   assign unl_go = take && (st_ready || st_inhibit) && (lk_code_r == `FWP_CMD_REGION_UNLOCK);
   assign pd_go = take && st_ready && (lk_code_r == `FWP_CMD_POWER_DOWN);
   assign rdp_go = take && st_pdown && (lk_code_r == `FWP_CMD_POWER_UP);
   assign arm_go = take && (st_ready || st_inhibit) && (lk_code_r == `FWP_CMD_RESET_ARM);
   assign rst_go = take && (st_ready || st_inhibit) && reset_armed_r
                   && (lk_code_r == `FWP_CMD_RESET_GO);
   assign read_ok = take && !st_pdown && (lk_code_r == `FWP_CMD_STATUS1_RD
                    || lk_code_r == `FWP_CMD_STATUS2_RD || lk_code_r == `FWP_CMD_STATUS3_RD);
   assign susp_ok = take && st_busy && (lk_code_r == `FWP_CMD_SUSPEND);
   assign unl_idx = fwp_lock_index(lk_addr_r);

   // main state: inhibit after supply reset, then ready, busy or powered down
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= fwp_pkg::FWP_ST_INHIBIT;
      end else begin
         case (state_r)
            fwp_pkg::FWP_ST_INHIBIT: begin
               if (puw_cnt_r == PUW_W'(PUW_CYCLES - 1)) begin
                  state_r <= fwp_pkg::FWP_ST_READY;
               end
            end
            fwp_pkg::FWP_ST_READY: begin
               if (go_op) begin
                  state_r <= fwp_pkg::FWP_ST_BUSY;
               end else if (pd_go) begin
                  state_r <= fwp_pkg::FWP_ST_PDOWN;
               end
            end
            fwp_pkg::FWP_ST_BUSY: begin
               if (op_done) begin
                  state_r <= fwp_pkg::FWP_ST_READY;
               end
            end
            fwp_pkg::FWP_ST_PDOWN: begin
               if (rdp_go) begin
                  state_r <= fwp_pkg::FWP_ST_READY;
               end
            end
            default: state_r <= fwp_pkg::FWP_ST_INHIBIT;
         endcase
      end
   end

   // power-up inhibit and operation timers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         puw_cnt_r <= '0;
         op_cnt_r <= '0;
      end else begin
         puw_cnt_r <= st_inhibit ? puw_cnt_r + PUW_W'(1) : '0;
         op_cnt_r <= st_busy ? op_cnt_r + OP_W'(1) : '0;
      end
   end

   // write-enable latch; an operation clears it both at start and at finish
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wel_r <= 1'b0;
      end else if (go_op || wrdi_go || op_done || rst_go) begin
         wel_r <= 1'b0;
      end else if (wren_go) begin
         wel_r <= 1'b1;
      end
   end

   // two-instruction software reset sequence
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_armed_r <= 1'b0;
      end else if (take) begin
         reset_armed_r <= arm_go;
      end
   end

   // protect fields; lock-down mode only clears by the supply reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bp_r <= `FWP_BP_RST;
         tb_r <= `FWP_BIT_RST;
         sec_r <= `FWP_BIT_RST;
         protect_mode_low_r <= `FWP_BIT_RST;
         protect_mode_high_r <= `FWP_BIT_RST;
         qe_r <= `FWP_BIT_RST;
         cmp_r <= `FWP_BIT_RST;
         wps_r <= `FWP_BIT_RST;
      end else if (go_op && lk_code_r == `FWP_CMD_STATUS_WR) begin
         bp_r <= lk_data_r[`FWP_S1_BP_HI:`FWP_S1_BP_LO];
         tb_r <= lk_data_r[`FWP_S1_TB];
         sec_r <= lk_data_r[`FWP_S1_SEC];
         protect_mode_low_r <= lk_data_r[`FWP_S1_PROTECT_MODE_LOW];
         protect_mode_high_r <= lk_data_r[8 + `FWP_S2_PROTECT_MODE_HIGH];
         qe_r <= lk_data_r[8 + `FWP_S2_QE];
         cmp_r <= lk_data_r[8 + `FWP_S2_CMP];
      end else if (go_op && lk_code_r == `FWP_CMD_STATUS3_WR) begin
         wps_r <= lk_data_r[`FWP_S3_WPS];
      end
   end

   // one lock bit per region, all set at power-on and on software reset
   genvar gi;
   generate
      for (gi = 0; gi < LOCKS; gi++) begin : g_lock
         always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               lock_r[gi] <= `FWP_LOCK_RST;
            end else if (rst_go) begin
               lock_r[gi] <= `FWP_LOCK_RST;
            end else if (unl_go && unl_idx == LOCK_W'(gi)) begin
               lock_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // operation launch and refusal reporting
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         op_start_r <= 1'b0;
         op_kind_r <= fwp_pkg::FWP_OP_NONE;
         op_addr_r <= '0;
         cmd_ignored_r <= 1'b0;
      end else begin
         op_start_r <= go_op;
         if (go_op) begin
            op_kind_r <= op_nxt;
            op_addr_r <= lk_addr_r;
         end
         cmd_ignored_r <= take && !(go_op || wren_go || wrdi_go || unl_go || pd_go || rdp_go
                          || arm_go || rst_go || read_ok || susp_ok);
      end
   end

   // outputs are flop bits; busy is the one-hot busy state bit
   assign status_one = {protect_mode_low_r, sec_r, tb_r, bp_r, wel_r, state_r[2]};
   assign status_two = {1'b0, cmp_r, 3'h0, 1'b0, qe_r, protect_mode_high_r};
   assign protect_scheme_select = wps_r;
   assign op_start = op_start_r;
   assign op_kind = op_kind_r;
   assign op_addr = op_addr_r;
   assign cmd_ignored = cmd_ignored_r;

   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   a_wel_before_op: assert property (op_start |-> $past(wel_r))
      else $error("operation launched without write enable");
   a_wel_after_op: assert property (go_op |=> !wel_r [*2])
      else $error("latch not cleared by operation");
   a_busy_follows: assert property (go_op |=> status_one[0] ##[1:1000] !status_one[0])
      else $error("busy bit not set or never cleared");
   a_done_clears: assert property (op_done |=> !wel_r && !status_one[0])
      else $error("finish did not clear latch and busy");
   a_inhibit_wren: assert property (st_inhibit && take |=> !wel_r)
      else $error("write enable taken during power-up inhibit");
   a_pdown_ignore: assert property (st_pdown && take && lk_code_r != `FWP_CMD_POWER_UP
                                    |=> cmd_ignored && status_one == $past(status_one))
      else $error("instruction obeyed in power-down");
   a_busy_ignore: assert property (st_busy && take && !susp_ok && !read_ok
                                   |=> cmd_ignored ##1 !op_start)
      else $error("instruction obeyed while busy");
   a_array_guard: assert property (go_op && op_nxt != fwp_pkg::FWP_OP_STATUS_WR
                                   |-> !prot_hit)
      else $error("protected region operation launched");
   a_range_guard: assert property (take && st_ready && !wps_r && bp_r == 3'h7 && !cmp_r
                                   && op_nxt == fwp_pkg::FWP_OP_PROG |=> !op_start)
      else $error("program launched into fully protected array");
   a_mode_lock: assert property (take && protect_mode_high_r && op_nxt == fwp_pkg::FWP_OP_STATUS_WR
                                 |=> !op_start)
      else $error("status write accepted under lock-down");
   a_pin_lock: assert property (take && st_ready && protect_mode_low_r && !protect_mode_high_r && !qe_r && !wp_s2_r
                                && op_nxt == fwp_pkg::FWP_OP_STATUS_WR |=> !op_start)
      else $error("status write accepted with pin low");
   a_quad_pin: assert property (take && st_ready && wel_r && protect_mode_low_r && !protect_mode_high_r && qe_r
                                && lk_code_r == `FWP_CMD_STATUS_WR |=> op_start)
      else $error("pin still gates status write in quad mode");
   a_unlock_bit: assert property (unl_go && !rst_go |=> lock_r[$past(unl_idx)] == 1'b0)
      else $error("unlock did not clear lock bit");
   a_soft_reset: assert property (rst_go |=> &lock_r && !wel_r)
      else $error("reset did not set lock bits");

   c_program: cover property (go_op && op_nxt == fwp_pkg::FWP_OP_PROG ##[1:1000] op_done);
   c_unlock_prog: cover property (unl_go ##[1:100] go_op);
   c_power_down: cover property (pd_go ##[1:100] rdp_go);
   c_status_wr: cover property (go_op && op_nxt == fwp_pkg::FWP_OP_STATUS_WR);
endmodule

`default_nettype wire

// ==== verilog/fwp_consts.svh ====
// Purpose: constants for the flash write-protect and status block
// Assumes: 40 MHz core clock, byte-wide instruction codes
// Notes:   bit positions are within each 8-bit status register
`ifndef FWP_CONSTS_SVH
`define FWP_CONSTS_SVH

// instruction codes
`define FWP_CMD_WR_ENABLE 8'h06
`define FWP_CMD_WR_DISABLE 8'h04
`define FWP_CMD_STATUS_WR 8'h01
`define FWP_CMD_STATUS3_WR 8'h11
`define FWP_CMD_STATUS1_RD 8'h05
`define FWP_CMD_STATUS2_RD 8'h35
`define FWP_CMD_STATUS3_RD 8'h15
`define FWP_CMD_PAGE_PROG 8'h02
`define FWP_CMD_QUAD_PROG 8'h32
`define FWP_CMD_SECT_ERASE 8'h20
`define FWP_CMD_BLOCK_ERASE 8'hD8
`define FWP_CMD_CHIP_ERASE 8'hC7
`define FWP_CMD_CHIP_ERASE2 8'h60
`define FWP_CMD_SECREG_ERASE 8'h44
`define FWP_CMD_SECREG_PROG 8'h42
`define FWP_CMD_REGION_UNLOCK 8'h39
`define FWP_CMD_POWER_DOWN 8'hB9
`define FWP_CMD_POWER_UP 8'hAB
`define FWP_CMD_SUSPEND 8'h75
`define FWP_CMD_RESET_ARM 8'h66
`define FWP_CMD_RESET_GO 8'h99

// status register one bit positions
`define FWP_S1_BUSY 0
`define FWP_S1_WEL 1
`define FWP_S1_BP_LO 2
`define FWP_S1_BP_HI 4
`define FWP_S1_TB 5
`define FWP_S1_SEC 6
`define FWP_S1_PROTECT_MODE_LOW 7
// status register two bit positions
`define FWP_S2_PROTECT_MODE_HIGH 0
`define FWP_S2_QE 1
`define FWP_S2_CMP 6
// status register three bit position
`define FWP_S3_WPS 2

// factory defaults
`define FWP_BP_RST 3'h0
`define FWP_BIT_RST 1'b0
`define FWP_LOCK_RST 1'b1

// array geometry
`define FWP_BLK_LSB 16
`define FWP_SECT_LSB 12
`define FWP_SECTOR_BYTES 32'h0000_1000
`define FWP_BLOCK_BYTES 32'h0001_0000
`define FWP_PAGE_MASK 32'h0000_00FF
`define FWP_SECT_MASK 32'h0000_0FFF
`define FWP_BLOCK_MASK 32'h0000_FFFF
`define FWP_EDGE_SECTORS 32

// timing
`define FWP_CORE_MHZ 40
`define FWP_PUW_TIME_US 5000
`define FWP_OP_TIME_US 10
`define FWP_OP_CYCLES ((`FWP_OP_TIME_US) * (`FWP_CORE_MHZ))

`endif

// ==== verilog/fwp_pkg.sv ====
// Purpose: types for the flash write-protect and status block
// Assumes: nothing beyond the consts header
// Notes:   one-hot state codes
package fwp_pkg;
   typedef enum logic [3:0] {
      FWP_ST_INHIBIT = 4'h1,
      FWP_ST_READY = 4'h2,
      FWP_ST_BUSY = 4'h4,
      FWP_ST_PDOWN = 4'h8
   } fwp_state_t;

   typedef enum logic [2:0] {
      FWP_OP_NONE = 3'h0,
      FWP_OP_PROG = 3'h1,
      FWP_OP_SECT_ERASE = 3'h2,
      FWP_OP_BLOCK_ERASE = 3'h3,
      FWP_OP_CHIP_ERASE = 3'h4,
      FWP_OP_STATUS_WR = 3'h5,
      FWP_OP_SECREG = 3'h6
   } fwp_op_t;
endpackage

// ==== testbench/fwp_host_model.sv ====
// Purpose: host issuing decoded flash instructions on the link clock
// Assumes: one instruction per call, 32 ns link period
// Notes:   link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module fwp_host_model (
   output logic spi_clk,
   output logic cmd_strobe,
   output logic [7:0] cmd_code,
   output logic [21:0] cmd_addr,
   output logic [15:0] cmd_data
);
   initial {spi_clk, cmd_strobe, cmd_code, cmd_addr, cmd_data} = '0;
   // released lines flip so a stale code can never pass as fresh
   task automatic send(input logic [7:0] c, input logic [21:0] a,
      input logic [15:0] d, input int slow);
      #(16 + 32 * slow);
      {cmd_code, cmd_addr, cmd_data} = {c, a, d};
      cmd_strobe = 1'b1;
      #16 spi_clk = 1'b1;
      #16 spi_clk = 1'b0;
      cmd_strobe = 1'b0;
      {cmd_code, cmd_addr, cmd_data} = ~{c, a, d};
      #16 spi_clk = 1'b1;
      #16 spi_clk = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the write-protect block
// Assumes: short inhibit and operation counts
// Notes:   acceptance predicted by a small behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", n, e, s); end end
module testbench;
   logic core_clk, reset_n, wp_n_pin, spi_clk, cmd_strobe, op_start, cmd_ignored, scheme;
   logic [7:0] cmd_code, status_one, status_two, s1, s2;
   logic [21:0] cmd_addr, op_addr;
   logic [15:0] cmd_data;
   logic [2:0] op_kind;
   logic [24:0] q[$];
   logic [24:0] ex;
   bit write_enable_latch, pd, bz, sch, inh, wp;
   bit [63:0] lck;
   int seed = 53;
   int n_mismatch, tests_run, n_ign, n_start;
   fwp_host_model host (.spi_clk(spi_clk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data));
   fwp_write_protect #(.BLOCKS(64), .PUW_CYCLES(50), .OP_CYCLES(20)) DUT (
      .core_clk(core_clk), .reset_n(reset_n), .spi_clk(spi_clk), .cmd_strobe(cmd_strobe),
      .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .wp_n_pin(wp_n_pin),
      .status_one(status_one), .status_two(status_two), .protect_scheme_select(scheme),
      .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr), .cmd_ignored(cmd_ignored));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // pulse counters and launch checks against the queue
   always @(posedge core_clk) begin
      if (cmd_ignored === 1'b1) n_ign++;
      if (op_start === 1'b1) begin
         n_start++;
         ex = q.pop_front();
         `CHK("op_kind", ex[24:22], op_kind)
         if (ex[24:22] == 3'h1) `CHK("op_addr", ex[21:0], op_addr)
      end
   end
   // model of acceptance; range counted in 4KB sectors, sector granules stop at eight
   function automatic bit ok(input logic [7:0] c, input logic [21:0] a);
      int b;
      int n;
      bit p;
      b = a[21:12];
      n = s1[4:2] == 3'h0 ? 0 : 1 << (s1[4:2] - 1 + (s1[6] ? 0 : 4));
      if (s1[6] && s1[4:2] > 3'h4) n = 8;
      if (s1[4:2] == 3'h7) n = 1024;
      p = (s1[5] ? b < n : b >= 1024 - n) ^ s2[6];
      if (sch) p = lck[a[21:16]];
      if (pd) return c == 8'hAB;
      if (bz) return 0;
      if (inh && c inside {8'h06, 8'h02, 8'h01, 8'h11, 8'hB9}) return 0;
      if (c == 8'h02) return write_enable_latch && !p;
      if (c inside {8'h01, 8'h11}) return write_enable_latch && !s2[0] && !(s1[7] && !wp && !s2[1]);
      return 1;
   endfunction
   task automatic upd(input logic [7:0] c, input logic [21:0] a, input logic [15:0] d);
      case (c)
         8'h06: write_enable_latch = 1;
         8'h01: begin
            s1[7:2] = d[7:2];
            s2 = d[15:8] & 8'h43;
         end
         8'h11: sch = d[2];
         8'h39: lck[a[21:16]] = 0;
         8'hB9: pd = 1;
         8'hAB: pd = 0;
         8'h99: lck = '1;
         default: ;
      endcase
      if (c inside {8'h04, 8'h01, 8'h11, 8'h02, 8'h99}) write_enable_latch = 0;
   endtask
   task automatic cmd(input logic [7:0] c, input logic [21:0] a, input logic [15:0] d,
      input bit w = 1);
      bit e;
      int i0;
      int s0;
      int k;
      e = ok(c, a);
      i0 = n_ign;
      s0 = n_start;
      if (e && c inside {8'h01, 8'h02, 8'h11})
         q.push_back(c == 8'h02 ? {3'h1, a} : {3'h5, 22'h0});
      host.send(c, a, d, $random(seed) & 1);
      repeat (10) @(posedge core_clk);
      `CHK("ignored", !e, n_ign != i0)
      `CHK("start", e && c inside {8'h01, 8'h02, 8'h11}, n_start != s0)
      if (c inside {8'h01, 8'h02, 8'h11}) `CHK("busy", e, status_one[0])
      if (e) upd(c, a, d);
      for (k = 0; k < 200 && w && status_one[0] !== 1'b0; k++) @(posedge core_clk);
      if (w) `CHK("status_one", {s1[7:2], write_enable_latch, 1'b0}, status_one)
      `CHK("status_two", s2, status_two)
      `CHK("scheme", sch, scheme)
   endtask
   task automatic prog(input logic [21:0] a);
      cmd(8'h06, 0, 0);
      cmd(8'h02, a, 0);
   endtask
   task automatic wsr(input logic [15:0] d);
      cmd(8'h06, 0, 0);
      cmd(8'h01, 0, d);
   endtask
   task automatic setwp(input bit v);
      @(posedge core_clk) wp_n_pin <= v;
      wp = v;
      repeat (4) @(posedge core_clk);
   endtask
   // supply reset: non-volatile bits and locks back to defaults
   task automatic power_up();
      @(posedge core_clk) reset_n <= 1'b0;
      {write_enable_latch, pd, bz, sch} = '0;
      {s1, s2} = '0;
      inh = 1;
      lck = '1;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #500000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      reset_n = 1'b0;
      wp_n_pin = 1'b1;
      wp = 1;
      power_up();
      cmd(8'h06, 0, 0);
      repeat (60) @(posedge core_clk);
      inh = 0;
      cmd(8'h02, 22'($random(seed)), 0);
      cmd(8'h06, 0, 0);
      cmd(8'h02, 22'($random(seed)), 0, 0);
      bz = 1;
      cmd(8'h06, 0, 0);
      bz = 0;
      $display("test latch and busy done");
      `CHK("queue", 0, q.size())
      for (int i = 0; i < 4; i++) begin
         wsr(i[1] ? (i[0] ? 16'h4004 : 16'h001C) : (i[0] ? 16'h0038 : 16'h0004));
         prog(22'h3F0000);
         prog(22'h000000);
         prog(22'($random(seed)));
      end
      wsr(16'h0044);
      prog(22'h3FF000);
      prog(22'h3FE000);
      $display("test range done");
      cmd(8'h06, 0, 0);
      cmd(8'h11, 0, 16'h0004);
      prog(22'h050000);
      cmd(8'h39, 22'h050000, 0);
      prog(22'h050000);
      $display("test locks done");
      wsr(16'h0080);
      setwp(0);
      wsr(16'h0080);
      setwp(1);
      wsr(16'h0280);
      setwp(0);
      wsr(16'h0380);
      wsr(16'h0000);
      $display("test modes done");
      cmd(8'hB9, 0, 0);
      cmd(8'h06, 0, 0);
      cmd(8'hAB, 0, 0);
      cmd(8'h04, 0, 0);
      power_up();
      cmd(8'h05, 0, 0);
      repeat (60) @(posedge core_clk);
      inh = 0;
      cmd(8'h06, 0, 0);
      cmd(8'h11, 0, 16'h0004);
      prog(22'h050000);
      cmd(8'h39, 22'h050000, 0);
      cmd(8'h66, 0, 0);
      cmd(8'h99, 0, 0);
      prog(22'h050000);
      $display("test power cycle done");
      wrap_up();
   end
endmodule
`default_nettype wire
